// file: verilog/sup_pkg.sv
package sup_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths and clock.
	localparam int MEAS_W = 16;
	localparam int CNT_W = 29;
	localparam int EVT_N = 5;
	localparam int ALARM_N = 9;
	localparam int unsigned CLK_HZ = 32'h0131_2D00;

	////////////////////////////////////////////////////////////////////////////
	// Timing: seconds as printed, cycles derived from the clock rate.
	localparam int unsigned PF_ACK_HOLD_S = 32'h0000_000F;
	localparam int unsigned PF_RESTART_S = 32'h0000_0005;
	localparam int unsigned PF_ACK_HOLD_DEF = PF_ACK_HOLD_S * CLK_HZ;
	localparam int unsigned PF_RESTART_DEF = PF_RESTART_S * CLK_HZ;

	////////////////////////////////////////////////////////////////////////////
	// Nominal quantities in measurement units.
	localparam logic [31:0] NOM_V = 32'h0000_2000;
	localparam logic [31:0] NOM_I = 32'h0000_2000;
	localparam logic [31:0] NOM_P = 32'h0000_2000;
	localparam logic [31:0] PCT_DIV = 32'h0000_0064;
	localparam logic [31:0] PCT_THR = 32'h0000_006E;
	localparam logic [31:0] PCT_FIXED = 32'h0000_0065;

	// Protection thresholds reset to 110 % and may not be set above it.
	localparam logic [MEAS_W-1:0] THR_DEF_V = MEAS_W'(NOM_V * PCT_THR / PCT_DIV);
	localparam logic [MEAS_W-1:0] THR_DEF_I = MEAS_W'(NOM_I * PCT_THR / PCT_DIV);
	localparam logic [MEAS_W-1:0] THR_DEF_P = MEAS_W'(NOM_P * PCT_THR / PCT_DIV);
	localparam logic [MEAS_W-1:0] FIXED_OV_LIMIT = MEAS_W'(NOM_V * PCT_FIXED / PCT_DIV);

	////////////////////////////////////////////////////////////////////////////
	// Alarm vector bit positions.
	localparam int A_OV = 0;
	localparam int A_OC = 1;
	localparam int A_OP = 2;
	localparam int A_PF = 3;
	localparam int A_OT = 4;
	localparam int A_LINK = 5;
	localparam int A_FIXOV = 6;
	localparam int A_SHARE = 7;
	localparam int A_EVT = 8;

	// Events: 0 high voltage, 1 low voltage, 2 high current, 3 low current, 4 high power.
	// Source 0 is voltage, 1 current, 2 power.
	localparam logic [EVT_N-1:0][1:0] EVT_SRC = {2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
	localparam logic [EVT_N-1:0] EVT_BELOW = 5'h0A;

	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_SIGNAL = 2'h1,
		ACT_WARNING = 2'h2,
		ACT_ALARM = 2'h3
	} evt_action_t;

	typedef struct packed {
		logic [MEAS_W-1:0] volt;
		logic [MEAS_W-1:0] curr;
		logic [MEAS_W-1:0] pwr;
	} meas_t;

	typedef struct packed {
		logic [MEAS_W-1:0] ov;
		logic [MEAS_W-1:0] oc;
		logic [MEAS_W-1:0] op;
	} prot_thr_t;

	typedef struct packed {
		evt_action_t [EVT_N-1:0] action;
		logic [EVT_N-1:0][MEAS_W-1:0] thr;
	} evt_cfg_t;

	typedef struct packed {
		logic mains_bad;
		logic overtemp;
		logic slave_lost;
		logic share_attn;
		logic share_wired;
	} hw_fault_t;

endpackage

// file: verilog/event_slot.sv
`timescale 1ns/10ps
module event_slot (
	input wire logic i_enable,
	input wire logic i_below,
	input wire logic [sup_pkg::MEAS_W-1:0] i_value,
	input wire logic [sup_pkg::MEAS_W-1:0] i_thr,
	input wire sup_pkg::evt_action_t i_action,
	output logic o_sig,
	output logic o_warn,
	output logic o_alarm
);
	import sup_pkg::*;

	logic hit;

	// Conditions only count while the output is on, so a decaying voltage after switch-off raises nothing.
	assign hit = i_enable & (i_below ? (i_value < i_thr) : (i_value > i_thr));

	always_comb begin
		o_sig = 1'b0;
		o_warn = 1'b0;
		o_alarm = 1'b0;
		case (i_action)
			ACT_NONE: begin
				o_sig = 1'b0;
			end
			ACT_SIGNAL: begin
				o_sig = hit;
			end
			ACT_WARNING: begin
				o_sig = hit;
				o_warn = hit;
			end
			ACT_ALARM: begin
				o_alarm = hit;
			end
			default: begin
				o_sig = 1'b0;
			end
		endcase
	end
endmodule

// file: verilog/supply_alarm_event_monitor.sv
`timescale 1ns/10ps
//
// Contract
// - Action none: event fully ignored.
// - Action signal: status text, output stays.
// - Action warning: status text plus warning popup.
// - Action alarm: alarm, gated beep, output off.
// - All alarms readable; most on analog.
// - Alarms latch until acknowledged; the link alarm until reinit/exit.
// - Voltage at threshold trips, output off.
// - Current at threshold trips, output off.
// - Power at threshold trips, output off.
// - Mains failure alarms; restore is configurable.
// - Mains acknowledge refused 15 s after.
// - Output re-enable waits 5 s after mains.
// - Overtemperature alarms; restore is configurable.
// - Master link loss; cleared by reinit/exit.
// - Share bus attenuated or miswired faults.
// - Thresholds compared continuously, always.
// - Thresholds reset to 110 % nominal.
// - One enable gates the acoustic signal.
// - Events only while on; default none.
// - Five events against own thresholds.
module supply_alarm_event_monitor #(
	parameter int unsigned PF_ACK_HOLD_CYC = sup_pkg::PF_ACK_HOLD_DEF,
	parameter int unsigned PF_RESTART_CYC = sup_pkg::PF_RESTART_DEF
) (
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	input wire sup_pkg::meas_t i_meas,
	input wire logic i_thr_wr,
	input wire sup_pkg::prot_thr_t i_thr,
	input wire sup_pkg::evt_cfg_t i_evt_cfg,
	input wire sup_pkg::hw_fault_t i_fault,
	input wire logic i_is_master,
	input wire logic i_ms_mode,
	input wire logic i_ms_reinit,
	input wire logic i_variant_60v,
	input wire logic i_audio_en,
	input wire logic i_ack,
	input wire logic i_out_on,
	input wire logic i_out_off,
	input wire logic i_restore_after_pf,
	input wire logic i_restore_after_ot,
	output logic o_dc_on,
	output logic [sup_pkg::ALARM_N-1:0] o_alarms,
	output sup_pkg::prot_thr_t o_prot_thr,
	output logic [sup_pkg::EVT_N-1:0] o_status_txt,
	output logic o_warn_popup,
	output logic o_alarm_popup,
	output logic o_beep,
	output logic o_analog_alarm,
	output logic o_ack_blocked
);
	import sup_pkg::*;

	typedef struct packed {
		prot_thr_t thr;
		logic [ALARM_N-1:0] alarm;
		logic dc_on;
		logic restore;
		logic [CNT_W-1:0] ack_hold;
		logic [CNT_W-1:0] restart;
		logic [EVT_N-1:0] status_txt;
		logic warn_popup;
		logic alarm_popup;
		logic beep;
		logic analog_alarm;
		logic ack_blocked;
	} mon_state_t;

	localparam logic [CNT_W-1:0] ACK_HOLD_LOAD = CNT_W'(PF_ACK_HOLD_CYC);
	localparam logic [CNT_W-1:0] RESTART_LOAD = CNT_W'(PF_RESTART_CYC);
	localparam logic [ALARM_N-1:0] ANALOG_MASK = 9'h05F;

	mon_state_t st_q;
	mon_state_t st_d;
	logic [ALARM_N-1:0] cause;
	logic [ALARM_N-1:0] clr;
	logic [EVT_N-1:0] evt_sig;
	logic [EVT_N-1:0] evt_warn;
	logic [EVT_N-1:0] evt_alarm;
	logic any_alarm;
	logic ack_ok;

	////////////////////////////////////////////////////////////////////////////
	// User events, one slot each.
	genvar g;
	generate
		for (g = 0; g < EVT_N; g++) begin : gen_evt
			logic [MEAS_W-1:0] value;
			assign value = (EVT_SRC[g] == 2'h0) ? i_meas.volt :
				(EVT_SRC[g] == 2'h1) ? i_meas.curr : i_meas.pwr;
			event_slot u_slot (
				.i_enable(st_q.dc_on),
				.i_below(EVT_BELOW[g]),
				.i_value(value),
				.i_thr(i_evt_cfg.thr[g]),
				.i_action(i_evt_cfg.action[g]),
				.o_sig(evt_sig[g]),
				.o_warn(evt_warn[g]),
				.o_alarm(evt_alarm[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Causes. Comparisons run every cycle whatever the operator is doing.
	always_comb begin
		cause = '0;
		cause[A_OV] = i_meas.volt >= st_q.thr.ov;
		cause[A_OC] = i_meas.curr >= st_q.thr.oc;
		cause[A_OP] = i_meas.pwr >= st_q.thr.op;
		cause[A_PF] = i_fault.mains_bad;
		cause[A_OT] = i_fault.overtemp;
		cause[A_LINK] = i_is_master & i_ms_mode & i_fault.slave_lost;
		cause[A_FIXOV] = i_variant_60v & (i_meas.volt > FIXED_OV_LIMIT);
		cause[A_SHARE] = i_fault.share_attn | (i_fault.share_wired & ~i_ms_mode);
		cause[A_EVT] = |evt_alarm;
	end

	////////////////////////////////////////////////////////////////////////////
	// Clearing. The link alarm ignores acknowledge; the mains alarm waits out its hold.
	assign ack_ok = i_ack & (st_q.ack_hold == '0);

	always_comb begin
		clr = '0;
		for (int i = 0; i < ALARM_N; i++) begin
			clr[i] = i_ack & ~cause[i];
		end
		clr[A_PF] = ack_ok & ~cause[A_PF];
		clr[A_LINK] = (i_ms_reinit | ~i_ms_mode) & ~cause[A_LINK];
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		st_d = st_q;
		// A cause in the clearing cycle wins, so no trip is ever lost.
		st_d.alarm = (st_q.alarm & ~clr) | cause;
		any_alarm = |st_d.alarm;

		// Thresholds only load while the output is off and are clamped to 110 %.
		if (i_thr_wr & ~st_q.dc_on) begin
			st_d.thr.ov = (i_thr.ov > THR_DEF_V) ? THR_DEF_V : i_thr.ov;
			st_d.thr.oc = (i_thr.oc > THR_DEF_I) ? THR_DEF_I : i_thr.oc;
			st_d.thr.op = (i_thr.op > THR_DEF_P) ? THR_DEF_P : i_thr.op;
		end

		if (cause[A_PF]) begin
			st_d.ack_hold = ACK_HOLD_LOAD;
			st_d.restart = RESTART_LOAD;
		end else begin
			if (st_q.ack_hold != '0) begin
				st_d.ack_hold = st_q.ack_hold - 1'b1;
			end
			if (st_q.restart != '0) begin
				st_d.restart = st_q.restart - 1'b1;
			end
		end

		if (any_alarm) begin
			st_d.dc_on = 1'b0;
			if (st_q.dc_on & ((cause[A_PF] & i_restore_after_pf) | (cause[A_OT] & i_restore_after_ot))) begin
				st_d.restore = 1'b1;
			end
		end else if (i_out_off) begin
			st_d.dc_on = 1'b0;
			st_d.restore = 1'b0;
		end else if ((i_out_on | st_q.restore) & (st_q.restart == '0)) begin
			st_d.dc_on = 1'b1;
			st_d.restore = 1'b0;
		end

		st_d.status_txt = evt_sig;
		st_d.warn_popup = |evt_warn;
		st_d.alarm_popup = any_alarm;
		st_d.beep = i_audio_en & any_alarm;
		st_d.analog_alarm = |(st_d.alarm & ANALOG_MASK);
		st_d.ack_blocked = st_d.alarm[A_PF] & (st_d.ack_hold != '0);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			st_q <= '0;
			st_q.thr.ov <= THR_DEF_V;
			st_q.thr.oc <= THR_DEF_I;
			st_q.thr.op <= THR_DEF_P;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register.
	assign o_dc_on = st_q.dc_on;
	assign o_alarms = st_q.alarm;
	assign o_prot_thr = st_q.thr;
	assign o_status_txt = st_q.status_txt;
	assign o_warn_popup = st_q.warn_popup;
	assign o_alarm_popup = st_q.alarm_popup;
	assign o_beep = st_q.beep;
	assign o_analog_alarm = st_q.analog_alarm;
	assign o_ack_blocked = st_q.ack_blocked;

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	property p_none_quiet;
		(i_evt_cfg.action[0] == ACT_NONE) |=> !o_status_txt[0];
	endproperty
	a_none_quiet: assert property (p_none_quiet) else $error("event with action none gave indication");

	property p_signal_text;
		(o_dc_on && i_evt_cfg.action[0] == ACT_SIGNAL && i_meas.volt > i_evt_cfg.thr[0])
			|=> o_status_txt[0] && !o_warn_popup;
	endproperty
	a_signal_text: assert property (p_signal_text) else $error("signal action gave no status text");

	property p_warn_popup;
		(o_dc_on && i_evt_cfg.action[3] == ACT_WARNING && i_meas.curr < i_evt_cfg.thr[3])
			|=> o_status_txt[3] && o_warn_popup;
	endproperty
	a_warn_popup: assert property (p_warn_popup) else $error("warning action gave no popup");

	property p_evt_alarm_off;
		$rose(o_alarms[A_EVT]) |-> !o_dc_on && (o_beep == $past(i_audio_en));
	endproperty
	a_evt_alarm_off: assert property (p_evt_alarm_off) else $error("event alarm left output on");

	property p_ov_trip;
		(i_meas.volt >= o_prot_thr.ov) |=> o_alarms[A_OV] && !o_dc_on;
	endproperty
	a_ov_trip: assert property (p_ov_trip) else $error("voltage trip missed");

	property p_pf_ack_refused;
		(o_ack_blocked && i_ack) |=> o_alarms[A_PF];
	endproperty
	a_pf_ack_refused: assert property (p_pf_ack_refused) else $error("mains alarm acknowledged too early");

	property p_link_ack_ignored;
		(o_alarms[A_LINK] && i_ack && i_ms_mode && !i_ms_reinit) |=> o_alarms[A_LINK];
	endproperty
	a_link_ack_ignored: assert property (p_link_ack_ignored) else $error("link alarm cleared by acknowledge");

	property p_cause_holds;
		(o_alarms[A_OT] && i_ack && i_fault.overtemp) |=> o_alarms[A_OT];
	endproperty
	a_cause_holds: assert property (p_cause_holds) else $error("alarm cleared while cause present");

	property p_alarm_forces_off;
		(o_alarms != '0) |-> !o_dc_on && o_alarm_popup;
	endproperty
	a_alarm_forces_off: assert property (p_alarm_forces_off) else $error("output on with alarm active");

	property p_restart_wait;
		$fell(i_fault.mains_bad) |-> !o_dc_on [*2];
	endproperty
	a_restart_wait: assert property (p_restart_wait) else $error("output re-enabled right after mains failure");

	property p_oc_trip;
		(i_meas.curr >= o_prot_thr.oc) |=> o_alarms[A_OC] && !o_dc_on;
	endproperty
	a_oc_trip: assert property (p_oc_trip) else $error("current trip missed");

	property p_op_trip;
		(i_meas.pwr >= o_prot_thr.op) |=> o_alarms[A_OP] && !o_dc_on;
	endproperty
	a_op_trip: assert property (p_op_trip) else $error("power trip missed");

	property p_pf_alarm;
		i_fault.mains_bad |=> o_alarms[A_PF] && !o_dc_on;
	endproperty
	a_pf_alarm: assert property (p_pf_alarm) else $error("mains failure alarm missed");

	property p_pf_hold;
		$fell(i_fault.mains_bad) |-> o_ack_blocked;
	endproperty
	a_pf_hold: assert property (p_pf_hold) else $error("mains acknowledge hold not running");

	property p_ot_alarm;
		i_fault.overtemp |=> o_alarms[A_OT] && !o_dc_on;
	endproperty
	a_ot_alarm: assert property (p_ot_alarm) else $error("overtemperature alarm missed");

	property p_link_alarm;
		(i_is_master && i_ms_mode && i_fault.slave_lost) |=> o_alarms[A_LINK] && !o_dc_on;
	endproperty
	a_link_alarm: assert property (p_link_alarm) else $error("link loss alarm missed");

	property p_fixed_ov;
		(i_variant_60v && i_meas.volt > FIXED_OV_LIMIT) |=> o_alarms[A_FIXOV] && !o_dc_on;
	endproperty
	a_fixed_ov: assert property (p_fixed_ov) else $error("fixed overvoltage alarm missed");

	property p_share_fault;
		(i_fault.share_attn || (i_fault.share_wired && !i_ms_mode)) |=> o_alarms[A_SHARE];
	endproperty
	a_share_fault: assert property (p_share_fault) else $error("share bus fault missed");

	property p_latched;
		(o_alarms[A_OV] && !i_ack) |=> o_alarms[A_OV];
	endproperty
	a_latched: assert property (p_latched) else $error("alarm dropped without acknowledge");

	property p_thr_reset;
		$rose(i_rstn) |-> (o_prot_thr == {THR_DEF_V, THR_DEF_I, THR_DEF_P});
	endproperty
	a_thr_reset: assert property (p_thr_reset) else $error("thresholds not at default after reset");

	property p_thr_clamp;
		(o_prot_thr.ov <= THR_DEF_V) && (o_prot_thr.oc <= THR_DEF_I) && (o_prot_thr.op <= THR_DEF_P);
	endproperty
	a_thr_clamp: assert property (p_thr_clamp) else $error("threshold above its ceiling");

	property p_thr_locked;
		o_dc_on |=> $stable(o_prot_thr);
	endproperty
	a_thr_locked: assert property (p_thr_locked) else $error("threshold changed with output on");

	property p_beep_gate;
		!$past(i_audio_en) |-> !o_beep;
	endproperty
	a_beep_gate: assert property (p_beep_gate) else $error("beep with audio disabled");

	property p_beep_on;
		((o_alarms != '0) && $past(i_audio_en)) |-> o_beep;
	endproperty
	a_beep_on: assert property (p_beep_on) else $error("no beep on alarm with audio enabled");

	property p_analog;
		(o_alarms[A_OV] || o_alarms[A_PF] || o_alarms[A_OT]) |-> o_analog_alarm;
	endproperty
	a_analog: assert property (p_analog) else $error("alarm missing on analog output");

	property p_event_gated;
		!o_dc_on |=> (o_status_txt == '0) && !o_warn_popup;
	endproperty
	a_event_gated: assert property (p_event_gated) else $error("event indicated with output off");

	property p_low_event;
		(o_dc_on && i_evt_cfg.action[1] == ACT_SIGNAL && i_meas.volt < i_evt_cfg.thr[1])
			|=> o_status_txt[1];
	endproperty
	a_low_event: assert property (p_low_event) else $error("low voltage event missed");

	property p_high_power;
		(o_dc_on && i_evt_cfg.action[4] == ACT_SIGNAL && i_meas.pwr > i_evt_cfg.thr[4])
			|=> o_status_txt[4];
	endproperty
	a_high_power: assert property (p_high_power) else $error("high power event missed");

endmodule

// file: testbench/power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model
	import sup_pkg::*;
(
	input wire logic i_on,
	input wire meas_t i_set,
	output meas_t o_meas
);
	// A disabled stage reads zero, so a trip removes its own cause as on real hardware.
	assign o_meas = i_on ? i_set : '0;
endmodule

// file: testbench/tb_supply_alarm_event_monitor.sv
`timescale 1ns/10ps
module tb_supply_alarm_event_monitor;
	import sup_pkg::*;
	// Short hold and restart counts; restart exceeds hold so a refused switch-on is observable.
	localparam int HOLD = 20;
	localparam int RST = 40;
	logic clk = 0, rstn = 0, thr_wr = 0, mst = 0, ms = 0, reinit = 0, v60 = 0;
	logic aud = 0, ack = 0, on = 0, off = 0, rpf = 0, rot = 0;
	logic dc, wpop, apop, beep, ana, blk;
	logic [ALARM_N-1:0] al;
	logic [EVT_N-1:0] txt;
	meas_t set = '0, meas;
	prot_thr_t thr = '0, pthr;
	evt_cfg_t evt = '0;
	hw_fault_t flt = '0;
	int err_count = 0, tests_run = 0, cyc = 0;

	power_stage_model ps (.i_on(dc), .i_set(set), .o_meas(meas));
	supply_alarm_event_monitor #(.PF_ACK_HOLD_CYC(HOLD), .PF_RESTART_CYC(RST)) dut (
		.i_sys_clk(clk), .i_rstn(rstn), .i_meas(meas), .i_thr_wr(thr_wr), .i_thr(thr),
		.i_evt_cfg(evt), .i_fault(flt), .i_is_master(mst), .i_ms_mode(ms), .i_ms_reinit(reinit),
		.i_variant_60v(v60), .i_audio_en(aud), .i_ack(ack), .i_out_on(on), .i_out_off(off),
		.i_restore_after_pf(rpf), .i_restore_after_ot(rot), .o_dc_on(dc), .o_alarms(al),
		.o_prot_thr(pthr), .o_status_txt(txt), .o_warn_popup(wpop), .o_alarm_popup(apop),
		.o_beep(beep), .o_analog_alarm(ana), .o_ack_blocked(blk));

	////////////////////////////////////////////////////////////////////////////
	always #25 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk);
			#5;
		end
	endtask

	// Pulses one request for exactly one edge, then lets an idle edge pass so back-to-back calls never retoggle a strobe.
	// Codes: 0 on, 1 off, 2 ack, 3 threshold write, 4 reinit.
	task automatic hit(input int w);
		{reinit, thr_wr, ack, off, on} = 5'h1 << w;
		tick(1);
		{reinit, thr_wr, ack, off, on} = '0;
		tick(1);
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(6);
		rstn = 1;
		chk("rst_al", 0, al);
		chk("rst_ov", THR_DEF_V, pthr.ov);
		chk("rst_oc", THR_DEF_I, pthr.oc);
		chk("rst_op", THR_DEF_P, pthr.op);
		for (int k = 0; k < 3; k++) begin
			aud = k[0];
			hit(0);
			set[47 - 16 * k -: 16] = 16'hFFFF;
			tick(1);
			chk("trip", 1, al[k]);
			chk("trip_off", 0, dc);
			set = '0;
			tick(2);
			chk("latched", 1, al[k]);
			chk("analog", 1, ana);
			chk("popup", 1, apop);
			chk("beep", aud, beep);
			hit(2);
			chk("cleared", 0, al[k]);
		end
		thr = {16'h0100, 16'hFFFF, 16'h0200};
		hit(3);
		chk("thr_ov", 16'h0100, pthr.ov);
		chk("thr_oc", THR_DEF_I, pthr.oc);
		chk("thr_op", 16'h0200, pthr.op);
		hit(0);
		thr = '0;
		hit(3);
		chk("thr_hold", 16'h0100, pthr.ov);
		set.volt = 16'h00FF;
		tick(3);
		chk("below", 0, al[A_OV]);
		set.volt = 16'h0100;
		tick(1);
		chk("at_thr", 1, al[A_OV]);
		set = '0;
		hit(2);
		thr = {THR_DEF_V, THR_DEF_I, THR_DEF_P};
		hit(3);
		rot = 1;
		hit(0);
		flt.overtemp = 1;
		tick(1);
		chk("ot", 1, al[A_OT]);
		chk("ot_off", 0, dc);
		hit(2);
		chk("ot_held", 1, al[A_OT]);
		flt.overtemp = 0;
		tick(1);
		hit(2);
		chk("ot_clr", 0, al[A_OT]);
		tick(2);
		chk("ot_back", 1, dc);
		rot = 0;
		hit(1);
		hit(0);
		flt.mains_bad = 1;
		tick(1);
		chk("pf", 1, al[A_PF]);
		chk("pf_off", 0, dc);
		chk("blk", 1, blk);
		flt.mains_bad = 0;
		tick(HOLD / 2);
		hit(2);
		chk("pf_held", 1, al[A_PF]);
		tick(HOLD);
		chk("blk_end", 0, blk);
		hit(2);
		chk("pf_clr", 0, al[A_PF]);
		hit(0);
		chk("restart", 0, dc);
		tick(RST / 2);
		hit(0);
		chk("restart_end", 1, dc);
		mst = 1;
		ms = 1;
		flt.slave_lost = 1;
		tick(1);
		chk("link", 1, al[A_LINK]);
		chk("link_off", 0, dc);
		chk("ana_link", 0, ana);
		flt.slave_lost = 0;
		hit(2);
		chk("link_ack", 1, al[A_LINK]);
		hit(4);
		chk("link_clr", 0, al[A_LINK]);
		ms = 0;
		for (int b = 0; b < 2; b++) begin
			flt = hw_fault_t'(5'h1 << b);
			tick(1);
			chk("share", 1, al[A_SHARE]);
			flt = '0;
			hit(2);
			chk("share_clr", 0, al[A_SHARE]);
		end
		v60 = 1;
		hit(0);
		set.volt = FIXED_OV_LIMIT;
		tick(3);
		chk("fix_edge", 0, al[A_FIXOV]);
		set.volt = FIXED_OV_LIMIT + 16'h0001;
		tick(1);
		chk("fix_trip", 1, al[A_FIXOV]);
		set = '0;
		hit(2);
		v60 = 0;
		for (int a = 0; a < 4; a++) begin
			evt.action[0] = evt_action_t'(a);
			evt.thr[0] = 16'h1000;
			set.volt = 16'h1800;
			hit(0);
			tick(2);
			if (a < 3) chk("txt", a != 0, txt[0]);
			chk("warn", a == 2, wpop);
			chk("ev_alarm", a == 3, al[A_EVT]);
			chk("ev_on", a != 3, dc);
			set = '0;
			hit(1);
			hit(2);
		end
		// Low events would fire on the zero reading of a stopped output unless gated by the on state.
		for (int e = 1; e < 5; e++) begin
			evt = '0;
			evt.action[e] = (e == 3) ? ACT_WARNING : ACT_SIGNAL;
			evt.thr[e] = 16'h1000;
			set = {3{e[0] ? 16'h0800 : 16'h1800}};
			tick(2);
			chk("ev_idle", 0, txt);
			hit(0);
			tick(2);
			chk("ev_hit", 5'h01 << e, txt);
			chk("ev_warn", e == 3, wpop);
			hit(1);
		end
		rpf = 1;
		set = '0;
		hit(0);
		flt.mains_bad = 1;
		tick(1);
		flt.mains_bad = 0;
		chk("pf_rst", 1, al[A_PF]);
		tick(HOLD);
		hit(2);
		chk("pf_rst_clr", 0, al[A_PF]);
		chk("pf_wait", 0, dc);
		tick(RST);
		chk("pf_back", 1, dc);
		rpf = 0;
		print_verdict();
	end
endmodule
